// file: include/imufs_defines.svh
`ifndef IMUFS_DEFINES_SVH
`define IMUFS_DEFINES_SVH

`define IMUFS_CLK_NS       4.0
`define IMUFS_NS_PER_MS    1.0e6
`define IMUFS_ST_BEGIN_MS  11.5
`define IMUFS_ST_END_MS    75.5
`define IMUFS_FRAME_BITS   6'h20
`define IMUFS_CNT_MAX      6'h21
`define IMUFS_TX_LAST      5'h1E
`define IMUFS_CRC_INIT     4'hA
`define IMUFS_CRC_POLY     4'h1
`define IMUFS_MODE_DM      3'h5
`define IMUFS_FLAG_ALARM   2'h1
`define IMUFS_FLAG_OK      2'h2
`define IMUFS_ECHO         2'h2
`define IMUFS_SPI_ERR      28'h000_0090
`define IMUFS_CMD_ERR      28'h000_00A0
`define IMUFS_FIXED        16'hAA55
`define IMUFS_SEL_TEMP     4'hC
`define IMUFS_SEL_FIXED    4'hF
`define IMUFS_IDX_TEMP     4'h6
`define IMUFS_NTYPES       9

`endif

// file: include/imufs_pkg.sv
`include "imufs_defines.svh"
package imufs_pkg;
   // incoming command word, msb first
   typedef struct packed {
      logic [15:0] zero;
      logic [2:0]  mode;
      logic        rsvd;
      logic [3:0]  sel;
      logic        sync;
      logic [2:0]  rsvd3;
      logic [3:0]  crc;
   } imufs_cmd_t;
   // data monitor answer word
   typedef struct packed {
      logic [15:0] data;
      logic [1:0]  flag;
      logic [1:0]  echo;
      logic [3:0]  sel;
      logic        sync;
      logic        zero;
      logic [1:0]  keep_alive_count;
      logic [3:0]  crc;
   } imufs_resp_t;
   // live sample inputs: gyro xyz, accel xyz, temp1, temp2, diff
   typedef logic [`IMUFS_NTYPES-1:0][15:0] imufs_samples_t;
   typedef enum logic [2:0] {
      IMUFS_GR_300, IMUFS_GR_150, IMUFS_GR_120, IMUFS_GR_60, IMUFS_GR_30
   } imufs_grange_t;
   typedef enum logic [1:0] {
      IMUFS_AR_16, IMUFS_AR_8, IMUFS_AR_2, IMUFS_AR_1
   } imufs_arange_t;
   typedef enum logic [2:0] {
      IMUFS_LP_10, IMUFS_LP_12P5, IMUFS_LP_27, IMUFS_LP_30,
      IMUFS_LP_46, IMUFS_LP_60, IMUFS_LP_250, IMUFS_LP_300
   } imufs_lpf_t;
   typedef enum logic [1:0] {
      IMUFS_ST_WAIT = 2'b00,
      IMUFS_ST_TEST = 2'b01,
      IMUFS_ST_RUN  = 2'b11
   } imufs_st_t;

   // crc x^4+1, msb first
   function automatic logic [3:0] imufs_crc4(input logic [27:0] d);
      logic [3:0] c;
      logic       fb;
      c = `IMUFS_CRC_INIT;
      for (int i = 27; i >= 0; i--) begin
         fb = c[3] ^ d[i];
         c  = {c[2:0], 1'b0} ^ ({4{fb}} & `IMUFS_CRC_POLY);
      end
      return c;
   endfunction
endpackage

// file: hw/imufs_top.sv
`include "imufs_defines.svh"
module imufs_top #(
   parameter int unsigned ST_BEGIN_CYC = int'($ceil(
      `IMUFS_ST_BEGIN_MS * `IMUFS_NS_PER_MS / `IMUFS_CLK_NS)),
   parameter int unsigned ST_END_CYC = int'($floor(
      `IMUFS_ST_END_MS * `IMUFS_NS_PER_MS / `IMUFS_CLK_NS))
) (
   input  wire logic                    clk_sys,
   input  wire logic                    rst_n,
   input  wire logic                    sclk_i,
   input  wire logic                    chip_select_n_i,
   input  wire logic                    mosi_i,
   output logic                         miso_o,
   output logic                         miso_oe_n_o,
   input  wire imufs_pkg::imufs_samples_t samples_i,
   input  wire logic                    safety_alarm_i,
   output logic                         alarm_out_n,
   output imufs_pkg::imufs_grange_t     gyro_range_o,
   output imufs_pkg::imufs_arange_t     accel_range_o,
   output imufs_pkg::imufs_lpf_t        gyro_lpf_o,
   output imufs_pkg::imufs_lpf_t        accel_lpf_o
);
   import imufs_pkg::*;

   localparam int TW = $clog2(ST_END_CYC + 1);

   // refuse a self-test window the timer cannot serve
   if (ST_BEGIN_CYC < 1 || ST_BEGIN_CYC >= ST_END_CYC) begin : g_chk
      $error("self-test window is empty");
   end

   logic [1:0]     rst_q;
   logic           rst_s;
   logic           lnk_rst;
   logic           arm_q;
   logic           tog_q;
   logic [31:0]    rx_q;
   logic [5:0]     cnt_q;
   logic           bit_in;
   logic [4:0]     txn_q;
   logic           txb_q;
   logic           txgo_q;
   logic [2:0]     cs_q;
   logic [1:0]     tg_q;
   logic           tgl_q;
   logic           sync_pend_q;
   logic           fin;
   logic           fall;
   logic           seen;
   logic [5:0]     nbits;
   logic [5:0]     shamt;
   logic [31:0]    word;
   imufs_cmd_t     cmd;
   logic           crc_ok;
   logic           len_ok;
   logic           dec_ok;
   logic           known;
   logic           spi_err;
   logic           cmd_err;
   logic           good;
   logic [3:0]     idx;
   logic [15:0]    data;
   logic [1:0]     flag;
   logic [1:0]     keep_alive_count_d;
   imufs_resp_t    dresp;
   logic [27:0]    nxt_hi;
   logic [31:0]    resp_d;
   logic [31:0]    resp_q;
   logic [1:0]     keep_alive_count_q;
   logic           live_q;
   imufs_samples_t stored_q;
   imufs_st_t      st_q;
   logic [TW-1:0]  tmr_q;
   logic           alarm_out_n_q;

   // reset release through two flops
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) rst_q <= 2'h0;
      else        rst_q <= {rst_q[0], 1'b1};
   end
   assign rst_s   = rst_q[1];
   // first-edge and transmit logic restart whenever the frame is closed
   assign lnk_rst = chip_select_n_i | ~rst_s;

   // ---------------- link domain, on the serial clock -------------

   // first edge of a frame; sclk is idle outside frames
   always_ff @(posedge sclk_i or posedge lnk_rst) begin
      if (lnk_rst) arm_q <= 1'b1;
      else         arm_q <= 1'b0;
   end

   // beyond 32 clocks the input reads as low
   assign bit_in = (!arm_q && cnt_q >= `IMUFS_FRAME_BITS) ? 1'b0 : mosi_i;

   // receive shifter and count survive cs rise for the system side
   always_ff @(posedge sclk_i or negedge rst_s) begin
      if (!rst_s) begin
         rx_q  <= 32'h0000_0000;
         cnt_q <= 6'h00;
         tog_q <= 1'b0;
      end else begin
         rx_q <= {rx_q[30:0], bit_in};
         if (arm_q) begin
            cnt_q <= 6'h01;
            tog_q <= ~tog_q; // marks a frame that saw clocks
         end else if (cnt_q != `IMUFS_CNT_MAX) begin
            cnt_q <= cnt_q + 6'h01;
         end
      end
   end

   // transmit: bit 31 shows from cs fall, the rest after each fall
   always_ff @(negedge sclk_i or posedge lnk_rst) begin
      if (lnk_rst) begin
         txn_q  <= 5'h00;
         txb_q  <= 1'b0;
         txgo_q <= 1'b0;
      end else begin
         txgo_q <= 1'b1;
         if (txn_q <= `IMUFS_TX_LAST) begin
            txb_q <= resp_q[`IMUFS_TX_LAST - txn_q];
            txn_q <= txn_q + 5'h01;
         end else begin
            txb_q <= 1'b0;
         end
      end
   end
   // resp_q is quiet during a frame, so reading it here is safe
   assign miso_o      = txgo_q ? txb_q : resp_q[31];
   assign miso_oe_n_o = chip_select_n_i;

   // ---------------- system domain ---------------------------------

   // chip select and frame toggle synchronisers
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s) begin
         cs_q <= 3'h7;
         tg_q <= 2'h0;
      end else begin
         cs_q <= {cs_q[1:0], chip_select_n_i};
         tg_q <= {tg_q[0], tog_q};
      end
   end
   assign fin  = cs_q[1] & ~cs_q[2];
   assign fall = ~cs_q[1] & cs_q[2];
   // toggle moved since last frame end: clocks were seen
   assign seen = tg_q[1] ^ tgl_q;

   // toggle level kept at each frame end; the edge pulse is long gone by then
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s)   tgl_q <= 1'b0;
      else if (fin) tgl_q <= tg_q[1];
   end

   // rebuild the word; short frames repeat the last bit
   assign nbits = seen ? cnt_q : 6'h00;
   assign shamt = (nbits < `IMUFS_FRAME_BITS) ?
                  `IMUFS_FRAME_BITS - nbits : 6'h00;
   assign word  = (rx_q << shamt)
                | ({32{rx_q[0] & seen}} & ~(32'hFFFF_FFFF << shamt));
   assign cmd   = imufs_cmd_t'(word);

   // frame checks come before any decode
   assign len_ok  = (nbits == `IMUFS_FRAME_BITS);
   assign crc_ok  = (imufs_crc4(word[31:4]) == cmd.crc);
   assign dec_ok  = (cmd.zero == 16'h0000) && !cmd.rsvd
                 && (cmd.rsvd3 == 3'h0);
   assign spi_err = !len_ok || !crc_ok || !dec_ok;
   // odd codes below the temperature group are undefined
   assign known   = (cmd.mode == `IMUFS_MODE_DM)
                 && !(cmd.sel[0] && cmd.sel < `IMUFS_SEL_TEMP);
   assign cmd_err = !spi_err && !known;
   assign good    = !spi_err && known;

   // data select to stored slot; fixed value is a constant
   assign idx  = (cmd.sel >= `IMUFS_SEL_TEMP) ?
                 `IMUFS_IDX_TEMP + {2'h0, cmd.sel[1:0]} :
                 {1'b0, cmd.sel[3:1]};
   assign data = (cmd.sel == `IMUFS_SEL_FIXED) ? `IMUFS_FIXED :
                 stored_q[idx[3:0]];
   assign flag = safety_alarm_i ? `IMUFS_FLAG_ALARM
                                : `IMUFS_FLAG_OK;
   assign keep_alive_count_d = keep_alive_count_q + 2'h1;

   // answer word assembly
   always_comb begin
      dresp      = '0;
      dresp.data = data;
      dresp.flag = flag;
      dresp.echo = `IMUFS_ECHO;
      dresp.sel  = cmd.sel;
      dresp.sync = cmd.sync;
      dresp.keep_alive_count = keep_alive_count_d;
   end
   assign nxt_hi = spi_err ? `IMUFS_SPI_ERR :
                   cmd_err ? `IMUFS_CMD_ERR : dresp[31:4];
   assign resp_d = {nxt_hi, imufs_crc4(nxt_hi)};

   // answer for the next frame; a good frame replaces an error word
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s)   resp_q <= 32'h0000_0000;
      else if (fin) resp_q <= resp_d;
   end

   // keep-alive count, touched only by good reads
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s)           keep_alive_count_q <= 2'h0;
      else if (fin && good) keep_alive_count_q <= keep_alive_count_d;
   end

   // acquisition: live until a good command clears bit 7
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s)           live_q <= 1'b1;
      else if (fin && good) live_q <= cmd.sync;
   end

   // all types captured together at the cs fall
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s)              stored_q <= '0;
      else if (fall && live_q) stored_q <= samples_i;
   end

   // start-up self-test window on the alarm pin
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s) begin
         st_q  <= IMUFS_ST_WAIT;
         tmr_q <= '0;
      end else begin
         case (st_q)
            IMUFS_ST_WAIT: begin
               tmr_q <= tmr_q + TW'(1);
               if (tmr_q == TW'(ST_BEGIN_CYC - 1)) st_q <= IMUFS_ST_TEST;
            end
            IMUFS_ST_TEST: begin
               tmr_q <= tmr_q + TW'(1);
               if (tmr_q == TW'(ST_END_CYC - 1)) st_q <= IMUFS_ST_RUN;
            end
            IMUFS_ST_RUN: tmr_q <= tmr_q;
            default: st_q <= IMUFS_ST_RUN;
         endcase
      end
   end

   // pin low on alarm or during self-test
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s) alarm_out_n_q <= 1'b1;
      else alarm_out_n_q <= !(safety_alarm_i
                          || st_q == IMUFS_ST_TEST);
   end
   assign alarm_out_n = alarm_out_n_q;

   // volatile settings; nothing here rewrites them, reset restores
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s) begin
         gyro_range_o  <= IMUFS_GR_300;
         accel_range_o <= IMUFS_AR_8;
         gyro_lpf_o    <= IMUFS_LP_60;
         accel_lpf_o   <= IMUFS_LP_60;
      end else begin
         gyro_range_o  <= gyro_range_o;
         accel_range_o <= accel_range_o;
         gyro_lpf_o    <= gyro_lpf_o;
         accel_lpf_o   <= accel_lpf_o;
      end
   end

   // ---------------- checks ----------------------------------------

   // helper: a good sync command is owed a capture at the next cs fall
   always_ff @(posedge clk_sys or negedge rst_s) begin
      if (!rst_s)                       sync_pend_q <= 1'b0;
      else if (fall)                    sync_pend_q <= 1'b0;
      else if (fin && good && cmd.sync) sync_pend_q <= 1'b1;
   end

   sequence s_cs_rise;
      cs_q[1] && !cs_q[2];
   endsequence

   sequence s_good_end;
      s_cs_rise ##0 good;
   endsequence

   flag_alarm_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_good_end ##0 safety_alarm_i |=> resp_q[15:14] == 2'h1)
      else $error("flag not 01 under alarm");

   alarm_pin_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      safety_alarm_i |=> !alarm_out_n)
      else $error("alarm pin not low");

   selftest_win_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      $rose(st_q == IMUFS_ST_TEST) |->
         tmr_q == TW'(ST_BEGIN_CYC) ##1 !alarm_out_n)
      else $error("self-test start wrong");

   suspend_hold_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      !live_q |=> $stable(stored_q))
      else $error("samples moved while suspended");

   sync_capture_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      fall && sync_pend_q |=> stored_q == $past(samples_i))
      else $error("no capture after sync bit");

   keep_alive_count_step_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_good_end |=> keep_alive_count_q == $past(keep_alive_count_q) + 2'h1
                     && resp_q[5:4] == keep_alive_count_q)
      else $error("keep-alive count wrong");

   discard_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_cs_rise ##0 !good |=> $stable(keep_alive_count_q) && $stable(live_q))
      else $error("bad command acted on");

   spi_err_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_cs_rise ##0 !len_ok |=> resp_q[31:4] == `IMUFS_SPI_ERR)
      else $error("spi error word missing");

   cmd_err_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_cs_rise ##0 cmd_err |=> resp_q[31:4] == `IMUFS_CMD_ERR)
      else $error("command error word missing");

   resp_crc_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_cs_rise |=> resp_q[3:0] == imufs_crc4(resp_q[31:4]))
      else $error("answer crc wrong");

   resp_quiet_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      !fin |=> $stable(resp_q))
      else $error("answer moved mid frame");

   flag_ok_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_good_end ##0 !safety_alarm_i |=> resp_q[15:14] == `IMUFS_FLAG_OK)
      else $error("flag not 10 without alarm");

   selftest_end_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      $fell(st_q == IMUFS_ST_TEST) ##0 !safety_alarm_i |->
         tmr_q == TW'(ST_END_CYC) ##1 alarm_out_n)
      else $error("self-test end wrong");

   live_follow_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_good_end |=> live_q == $past(cmd.sync))
      else $error("capture state not set by bit 7");

   err_clear_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_good_end |=> resp_q[13:12] == `IMUFS_ECHO)
      else $error("error word not cleared");

   crc_err_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_cs_rise ##0 (len_ok && !crc_ok) |=> resp_q[31:4] == `IMUFS_SPI_ERR)
      else $error("bad crc not refused");

   dec_err_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_cs_rise ##0 (crc_ok && !dec_ok) |=> resp_q[31:4] == `IMUFS_SPI_ERR)
      else $error("bad decode not refused");

   fixed_word_a: assert property (
      @(posedge clk_sys) disable iff (!rst_s)
      s_good_end ##0 cmd.sel == `IMUFS_SEL_FIXED
         |=> resp_q[31:16] == `IMUFS_FIXED)
      else $error("fixed value wrong");
endmodule

// file: dv/imufs_host_model.sv
// host side of the link: spi master, mode 0, msb first
module imufs_host_model (
   output logic      sclk,
   output logic      cs_n,
   output logic      mosi,
   input  wire logic miso
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] rx_word;
   event        done;

   // idle: clock parked low, frame deselected
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      mosi = 1'b0;
      rx_word = '0;
   end

   // one frame of n clocks; odd delays keep it off the system clock grid
   task automatic xfer(input logic [31:0] w, input int n);
      cs_n = 1'b0;
      rx_word = '0;
      #(60.3);
      for (int i = 0; i < n; i++) begin
         mosi = (i < 32) ? w[31-i] : 1'b0;
         #20;
         sclk = 1'b1;
         if (i < 32) rx_word[31-i] = miso;
         #40;
         sclk = 1'b0;
         #20;
      end
      #30;
      cs_n = 1'b1;
      mosi = ~mosi; // stale level must not pass for data
      ->done;
      #(100.7);
   endtask
endmodule

// file: dv/imu_spi_frame_status_tb_top.sv
module imu_spi_frame_status_tb_top;
   import imufs_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned ST_B = 20;
   localparam int unsigned ST_E = 60;
   logic           clk_sys, rst_n, sclk, cs_n, mosi, miso, miso_oe_n;
   logic           safety_alarm, alarm_out_n, live_m;
   logic [1:0]     keep_alive_count_m;
   logic [31:0]    rnd;
   logic [31:0]    exp_q[$];
   imufs_samples_t samples, stored_m;
   imufs_grange_t  gr;
   imufs_arange_t  ar;
   imufs_lpf_t     gl, al;
   int             bad_count, n_compared, cyc;

   // self-test window shortened so the run stays brief
   imufs_top #(.ST_BEGIN_CYC(ST_B), .ST_END_CYC(ST_E)) dut_u (
      .clk_sys        (clk_sys),
      .rst_n          (rst_n),
      .sclk_i         (sclk),
      .chip_select_n_i(cs_n),
      .mosi_i         (mosi),
      .miso_o         (miso),
      .miso_oe_n_o    (miso_oe_n),
      .samples_i      (samples),
      .safety_alarm_i (safety_alarm),
      .alarm_out_n    (alarm_out_n),
      .gyro_range_o   (gr),
      .accel_range_o  (ar),
      .gyro_lpf_o     (gl),
      .accel_lpf_o    (al)
   );
   imufs_host_model host_u (.sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso));

   always #2 clk_sys = ~clk_sys;

   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   // bench's own crc, bit serial, init 0xa
   function automatic logic [3:0] crc_of(input logic [27:0] d);
      logic [3:0] c;
      c = 4'hA;
      for (int i = 27; i >= 0; i--) c = {c[2:0], 1'b0} ^ {3'b000, c[3] ^ d[i]};
      return c;
   endfunction

   task automatic chk(input string what, input logic [31:0] e,
                      input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic tally_and_finish();
      if (bad_count == 0 && n_compared > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // every finished frame carries the answer to the oldest note
   always @(host_u.done) begin
      if (exp_q.size() != 0) chk("miso word", exp_q.pop_front(), host_u.rx_word);
   end

   // the answer pin is enabled for the whole frame
   always @(posedge sclk)
      chk("miso enable", 32'h0, {31'b0, miso_oe_n});

   // hang guard, far above the ~20k cycles the run needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         bad_count++;
         tally_and_finish();
      end
   end

   // kind: 0 good, 1 bad crc, 2 short, 3 long, 4 reserved bit set
   task automatic send(input logic [3:0] sel, input logic sync,
                       input logic [2:0] mode, input int kind);
      logic [27:0]    c, r;
      logic [15:0]    d;
      imufs_samples_t nv;
      @(negedge clk_sys);
      rnd = xs(rnd);
      nv = 144'({rnd, ~rnd, rnd ^ 32'h5A5A_5A5A, rnd + 32'h1, rnd});
      samples <= nv;
      if (live_m) stored_m = nv;
      c = {16'h0000, mode, kind == 4, sel, sync, 3'b000};
      d = (sel == 4'hF) ? 16'hAA55 : stored_m[sel >= 4'hC ? sel - 4'h6 : sel >> 1];
      if (kind != 0) r = 28'h000_0090;
      else if (mode != 3'h5 || (sel[0] && sel < 4'hC)) r = 28'h000_00A0;
      else begin
         keep_alive_count_m++;
         live_m = sync;
         r = {d, safety_alarm ? 2'b01 : 2'b10, 2'b10, sel, sync, 1'b0, keep_alive_count_m};
      end
      exp_q.push_back({r, crc_of(r)});
      host_u.xfer({c, crc_of(c) ^ {3'b000, kind == 1}},
                  kind == 2 ? 31 : (kind == 3 ? 33 : 32));
   endtask

   initial begin
      clk_sys = 1'b0;
      rst_n = 1'b0;
      safety_alarm = 1'b0;
      samples = '0;
      stored_m = '0;
      rnd = 32'h0000_FD24;
      keep_alive_count_m = 2'b00;
      live_m = 1'b1;
      bad_count = 0;
      n_compared = 0;
      cyc = 0;
      exp_q.push_back(32'h0000_0000); // first answer after reset
      repeat (12) @(posedge clk_sys);
      @(negedge clk_sys) rst_n = 1'b1;
      chk("defaults", 32'({IMUFS_GR_300, IMUFS_AR_8, IMUFS_LP_60, IMUFS_LP_60}), 32'({gr, ar, gl, al}));
      repeat (10) @(negedge clk_sys);
      chk("alarm pin", 32'h1, {31'b0, alarm_out_n});
      repeat (30) @(negedge clk_sys);
      chk("alarm pin", 32'h0, {31'b0, alarm_out_n});
      repeat (40) @(negedge clk_sys);
      chk("alarm pin", 32'h1, {31'b0, alarm_out_n});
      // coherent read: latch again at the code 0 frame, then codes 1 to 15 with capture held
      send(4'hF, 1'b1, 3'h5, 0);
      for (int s = 0; s < 16; s++) send(s[3:0], 1'b0, 3'h5, 0);
      send(4'h0, 1'b1, 3'h4, 0);
      // faulty frames ask for capture, which must not happen
      // short frame first: 31 clocks never fetch bit 0 of the word it
      // carries, and the unrecognized-command word ends in a low bit
      for (int k = 0; k < 4; k++)
         send(4'h2, 1'b1, 3'h5, k < 2 ? 2 - k : k + 1);
      send(4'h4, 1'b1, 3'h5, 0);
      send(4'h6, 1'b0, 3'h5, 0);
      send(4'h8, 1'b0, 3'h5, 0);
      @(negedge clk_sys) safety_alarm = 1'b1;
      repeat (8) @(negedge clk_sys);
      chk("alarm pin", 32'h0, {31'b0, alarm_out_n});
      send(4'hC, 1'b0, 3'h5, 0);
      send(4'hE, 1'b0, 3'h5, 0);
      @(negedge clk_sys) safety_alarm = 1'b0;
      repeat (8) @(negedge clk_sys);
      chk("alarm pin", 32'h1, {31'b0, alarm_out_n});
      send(4'hD, 1'b0, 3'h5, 0);
      send(4'hF, 1'b0, 3'h5, 0);
      tally_and_finish();
   end
endmodule
